// ==== design/epwa_pkg.sv ====
package epwa_pkg;

   // Clock rate and data widths
   localparam int CLK_MHZ     = 200;
   localparam int CPU_DATA_W  = 16;
   localparam int PORT_DATA_W = 32;
   localparam int LANES       = 4;
   localparam int ADDR_LOW_W  = 4;
   localparam int ADDR_W_DEF  = 20;

   // Card strobe timing in ns
   localparam int SETUP_NS  = 10;
   localparam int STROBE_NS = 40;
   localparam int HOLD_NS   = 10;

   // Least times round up, never below one cycle
   function automatic int nsToCycCeil(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : nsToCycCeil

   localparam int SETUP_CYC  = nsToCycCeil(SETUP_NS);
   localparam int STROBE_CYC = nsToCycCeil(STROBE_NS);
   localparam int HOLD_CYC   = nsToCycCeil(HOLD_NS);
   localparam int CNT_W      = 4;

   // Card clock toggles every this many system cycles
   localparam int CLKOUT_HALF_CYC = 1;
   localparam int DIV_W           = 4;

   // Reset and idle values
   localparam logic [LANES-1:0]       LANES_OFF_N    = 4'hF;
   localparam logic [1:0]             HALF_OFF_N     = 2'h3;
   localparam logic [PORT_DATA_W-1:0] DATA_RESET     = 32'h0000_0000;
   localparam logic [CPU_DATA_W-1:0]  CPU_DATA_RESET = 16'h0000;
   localparam logic [CPU_DATA_W-1:0]  HALF_ZERO      = 16'h0000;

   // Bit positions in the synchronised pin bundle
   localparam int SYN_IRQ    = 0;
   localparam int SYN_STAT   = 4;
   localparam int SYN_TIN    = 6;
   localparam int SYN_SRX    = 8;
   localparam int SYN_CODEC  = 10;
   localparam int SYN_READY  = 11;
   localparam int SYN_JSHARE = 12;
   localparam int SYN_JWIDE  = 13;
   localparam int SYN_W      = 14;

   typedef enum logic [4:0] {
      ST_IDLE   = 5'h01,
      ST_SETUP  = 5'h02,
      ST_STROBE = 5'h04,
      ST_HOLD   = 5'h08,
      ST_DONE   = 5'h10
   } epwa_state_e;

   // Active-low lanes of one 16-bit half within the 32-bit word
   function automatic logic [LANES-1:0] laneMaskN(input logic half, input logic [1:0] laneN);
      return half ? {laneN, HALF_OFF_N} : {HALF_OFF_N, laneN};
   endfunction : laneMaskN

endpackage : epwa_pkg

// ==== design/epwa_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module epwa_pin_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] pinIn,
   output var  logic [WIDTH-1:0] pinOut
);

   if (WIDTH < 1) begin : g_badWidth
      $error("epwa_pin_sync: WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] stage1_r;
   logic [WIDTH-1:0] stage2_r;
   logic [WIDTH-1:0] stage3_r;
   wire  [WIDTH-1:0] agree;
   wire  [WIDTH-1:0] out_nxt;

   // A bit only moves once the last two stages agree
   assign agree   = ~(stage2_r ^ stage3_r);
   assign out_nxt = (stage3_r & agree) | (pinOut & ~agree);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         stage1_r <= RESET_VAL;
         stage2_r <= RESET_VAL;
         stage3_r <= RESET_VAL;
         pinOut   <= RESET_VAL;
      end else begin
         stage1_r <= pinIn;
         stage2_r <= stage1_r;
         stage3_r <= stage2_r;
         pinOut   <= out_nxt;
      end
   end

endmodule : epwa_pin_sync

`default_nettype wire

// ==== design/epwa_adapter.sv ====
`timescale 1ns/1ps
`default_nettype none

module epwa_adapter
   import epwa_pkg::*;
#(
   parameter int ADDR_W    = epwa_pkg::ADDR_W_DEF,
   parameter bit FULL_ADDR = 1'b1
) (
   input  wire logic                             sys_clk,
   input  wire logic                             rstn,
   input  wire logic                             cpuReq,
   input  wire logic                             cpuWrite,
   input  wire logic                             cpuSpace,
   input  wire logic [ADDR_W-1:0]                cpuAddr,
   input  wire logic [epwa_pkg::CPU_DATA_W-1:0]  cpuWdata,
   input  wire logic [1:0]                       cpuLaneN,
   output var  logic                             cpuAck,
   output var  logic [epwa_pkg::CPU_DATA_W-1:0]  cpuRdata,
   input  wire logic                             cpuCardReset,
   input  wire logic [1:0]                       cpuCtrl,
   output var  logic [1:0]                       cpuStatus,
   output var  logic [epwa_pkg::LANES-1:0]       cpuIrq,
   input  wire logic [1:0]                       cpuTimerOut,
   output var  logic [1:0]                       cpuTimerIn,
   input  wire logic [1:0]                       cpuSerialTx,
   output var  logic [1:0]                       cpuSerialRx,
   input  wire logic                             jumperShareCard,
   input  wire logic                             jumperWide,
   output var  logic [epwa_pkg::ADDR_LOW_W-1:0]  portAddrLow,
   output var  logic [ADDR_W-5:0]                portAddrHigh,
   output var  logic [epwa_pkg::PORT_DATA_W-1:0] portDataOut,
   output var  logic                             portDataOe,
   input  wire logic [epwa_pkg::PORT_DATA_W-1:0] portDataIn,
   output var  logic [epwa_pkg::LANES-1:0]       portByteLaneN,
   output var  logic                             portSelectPrimaryN,
   output var  logic                             portSelectSecondaryN,
   output var  logic                             portOutEnableN,
   output var  logic                             portReadStrobeN,
   output var  logic                             portWriteStrobeN,
   input  wire logic                             portReadyIn,
   input  wire logic                             cardIrqFirst,
   input  wire logic                             cardIrqSecond,
   input  wire logic                             cardIrqThird,
   input  wire logic                             cardIrqFourth,
   output var  logic                             cardResetN,
   output var  logic                             cardControlFirst,
   output var  logic                             cardControlSecond,
   input  wire logic                             cardStatusFirst,
   input  wire logic                             cardStatusSecond,
   output var  logic                             cardClockOut,
   input  wire logic                             timerInFirst,
   input  wire logic                             timerInSecond,
   output var  logic                             timerOutFirst,
   output var  logic                             timerOutSecond,
   input  wire logic                             serialRxDataFirst,
   input  wire logic                             serialRxDataSecond,
   output var  logic                             serialTxDataFirst,
   output var  logic                             serialTxDataSecond,
   output var  logic                             serialTxDataSecondOe,
   input  wire logic                             codecRx,
   output var  logic                             codecTx
);

   if (ADDR_W < 5 || STROBE_CYC >= (1 << CNT_W)
       || CLKOUT_HALF_CYC >= (1 << DIV_W)) begin : g_badParams
      $error("epwa_adapter: parameters out of range");
   end

   // Pin inputs, all through the three-stage filter
   wire [SYN_W-1:0]       syncIn;
   wire [SYN_W-1:0]       syncOut;
   wire [PORT_DATA_W-1:0] capData;

   assign syncIn = {jumperWide, jumperShareCard, portReadyIn, codecRx,
                    serialRxDataSecond, serialRxDataFirst, timerInSecond, timerInFirst,
                    cardStatusSecond, cardStatusFirst,
                    cardIrqFourth, cardIrqThird, cardIrqSecond, cardIrqFirst};

   epwa_pin_sync #(.WIDTH(SYN_W), .RESET_VAL('0)) pinSync (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .pinIn   (syncIn),
      .pinOut  (syncOut)
   );

   epwa_pin_sync #(.WIDTH(PORT_DATA_W), .RESET_VAL(DATA_RESET)) dataSync (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .pinIn   (portDataIn),
      .pinOut  (capData)
   );

   wire shareCard = syncOut[SYN_JSHARE];
   wire wideOn    = syncOut[SYN_JWIDE];
   wire readyOk   = syncOut[SYN_READY];

   assign cpuIrq     = syncOut[SYN_IRQ +: 4];
   assign cpuStatus  = syncOut[SYN_STAT +: 2];
   assign cpuTimerIn = syncOut[SYN_TIN +: 2];

   epwa_state_e state_r;
   epwa_state_e state_nxt;
   logic [CNT_W-1:0]       cnt_r, cnt_nxt;
   logic                   accWrite_r, accWrite_nxt;
   logic                   accFlush_r, accFlush_nxt;
   logic                   accSpace_r, accSpace_nxt;
   logic                   accWide_r, accWide_nxt;
   logic                   accHalf_r, accHalf_nxt;
   logic [ADDR_W-1:0]      accAddr_r, accAddr_nxt;
   logic [PORT_DATA_W-1:0] accData_r, accData_nxt;
   logic [LANES-1:0]       accLanesN_r, accLanesN_nxt;
   logic                   holdValid_r, holdValid_nxt;
   logic                   holdSpace_r, holdSpace_nxt;
   logic [ADDR_W-2:0]      holdAddr_r, holdAddr_nxt;
   logic [PORT_DATA_W-1:0] holdData_r, holdData_nxt;
   logic                   pend_r, pend_nxt;
   logic                   pendSpace_r, pendSpace_nxt;
   logic [ADDR_W-2:0]      pendAddr_r, pendAddr_nxt;
   logic [PORT_DATA_W-1:0] pendData_r, pendData_nxt;
   logic [LANES-1:0]       pendLanesN_r, pendLanesN_nxt;
   logic [CPU_DATA_W-1:0]  rdata_nxt;
   logic                   ack_nxt;
   logic [DIV_W-1:0]       div_r;

   // Request decode
   wire [ADDR_W-2:0]      wordAddr   = cpuAddr[ADDR_W-1:1];
   wire                   half       = cpuAddr[0];
   wire [ADDR_W-1:0]      wideAddr   = {1'b0, wordAddr};
   wire [ADDR_W-1:0]      pendAddrW  = {1'b0, pendAddr_r};
   wire                   holdHit    = holdValid_r && holdSpace_r == cpuSpace
                                       && holdAddr_r == wordAddr;
   wire                   pendHit    = pend_r && pendSpace_r == cpuSpace
                                       && pendAddr_r == wordAddr;
   wire [LANES-1:0]       newLanesN  = laneMaskN(half, cpuLaneN);
   wire [PORT_DATA_W-1:0] newData    = half ? {cpuWdata, HALF_ZERO} : {HALF_ZERO, cpuWdata};
   wire [PORT_DATA_W-1:0] newMask    = {{8{~newLanesN[3]}}, {8{~newLanesN[2]}},
                                        {8{~newLanesN[1]}}, {8{~newLanesN[0]}}};
   wire [PORT_DATA_W-1:0] mergedData = (newData & newMask) | (pendData_r & ~newMask);
   wire [LANES-1:0]       mergedLanN = pendLanesN_r & newLanesN;
   wire [CPU_DATA_W-1:0]  holdHalf   = half ? holdData_r[31:16] : holdData_r[15:0];
   wire [CPU_DATA_W-1:0]  capHalf    = (accWide_r && accHalf_r) ? capData[31:16]
                                                                 : capData[15:0];

   always_comb begin
      state_nxt      = state_r;
      cnt_nxt        = cnt_r;
      accWrite_nxt   = accWrite_r;
      accFlush_nxt   = accFlush_r;
      accSpace_nxt   = accSpace_r;
      accWide_nxt    = accWide_r;
      accHalf_nxt    = accHalf_r;
      accAddr_nxt    = accAddr_r;
      accData_nxt    = accData_r;
      accLanesN_nxt  = accLanesN_r;
      holdValid_nxt  = holdValid_r;
      holdSpace_nxt  = holdSpace_r;
      holdAddr_nxt   = holdAddr_r;
      holdData_nxt   = holdData_r;
      pend_nxt       = pend_r;
      pendSpace_nxt  = pendSpace_r;
      pendAddr_nxt   = pendAddr_r;
      pendData_nxt   = pendData_r;
      pendLanesN_nxt = pendLanesN_r;
      rdata_nxt      = cpuRdata;
      ack_nxt        = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (cpuReq) begin
               state_nxt    = ST_SETUP;
               cnt_nxt      = CNT_W'(SETUP_CYC - 1);
               accFlush_nxt = 1'b0;
               accWrite_nxt = cpuWrite;
               accSpace_nxt = cpuSpace;
               accWide_nxt  = wideOn;
               accHalf_nxt  = half;
               if (cpuWrite || !wideOn) begin
                  holdValid_nxt = 1'b0;
               end
               if (!wideOn) begin
                  accAddr_nxt   = cpuAddr;
                  accData_nxt   = {HALF_ZERO, cpuWdata};
                  accLanesN_nxt = {HALF_OFF_N, cpuLaneN};
               end else if (!cpuWrite && holdHit) begin
                  state_nxt = ST_DONE;
                  rdata_nxt = holdHalf;
                  ack_nxt   = 1'b1;
               end else if (cpuWrite && pendHit) begin
                  accAddr_nxt   = wideAddr;
                  accData_nxt   = mergedData;
                  accLanesN_nxt = mergedLanN;
               end else if (pend_r) begin
                  // Held half must reach the card before any other card access in wide mode
                  accFlush_nxt  = 1'b1;
                  accWrite_nxt  = 1'b1;
                  accSpace_nxt  = pendSpace_r;
                  accAddr_nxt   = pendAddrW;
                  accData_nxt   = pendData_r;
                  accLanesN_nxt = pendLanesN_r;
               end else if (cpuWrite) begin
                  state_nxt      = ST_DONE;
                  ack_nxt        = 1'b1;
                  pend_nxt       = 1'b1;
                  pendSpace_nxt  = cpuSpace;
                  pendAddr_nxt   = wordAddr;
                  pendData_nxt   = newData;
                  pendLanesN_nxt = newLanesN;
               end else begin
                  accAddr_nxt   = wideAddr;
                  accLanesN_nxt = '0;
               end
            end
         end
         ST_SETUP: begin
            if (cnt_r == '0) begin
               state_nxt = ST_STROBE;
               cnt_nxt   = CNT_W'(STROBE_CYC - 1);
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         ST_STROBE: begin
            if (cnt_r != '0) begin
               cnt_nxt = cnt_r - 1'b1;
            end else if (readyOk) begin
               state_nxt = ST_HOLD;
               cnt_nxt   = CNT_W'(HOLD_CYC - 1);
               if (!accWrite_r) begin
                  rdata_nxt     = capHalf;
                  holdData_nxt  = capData;
                  holdValid_nxt = accWide_r;
                  holdSpace_nxt = accSpace_r;
                  holdAddr_nxt  = accAddr_r[ADDR_W-2:0];
               end
            end
         end
         ST_HOLD: begin
            if (cnt_r != '0) begin
               cnt_nxt = cnt_r - 1'b1;
            end else begin
               state_nxt = accFlush_r ? ST_IDLE : ST_DONE;
               ack_nxt   = !accFlush_r;
               if (accWrite_r) begin
                  pend_nxt = 1'b0;
               end
            end
         end
         ST_DONE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   wire              active     = state_nxt == ST_SETUP || state_nxt == ST_STROBE
                                  || state_nxt == ST_HOLD;
   wire              strobing   = state_nxt == ST_STROBE;
   wire [LANES-1:0]  lanesN_nxt = active ? accLanesN_nxt : LANES_OFF_N;
   wire [ADDR_W-5:0] addrHi_nxt = FULL_ADDR ? accAddr_nxt[ADDR_W-1:4] : '0;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_r      <= ST_IDLE;
         cnt_r        <= '0;
         accWrite_r   <= 1'b0;
         accFlush_r   <= 1'b0;
         accSpace_r   <= 1'b0;
         accWide_r    <= 1'b0;
         accHalf_r    <= 1'b0;
         accAddr_r    <= '0;
         accData_r    <= DATA_RESET;
         accLanesN_r  <= LANES_OFF_N;
         holdSpace_r  <= 1'b0;
         holdAddr_r   <= '0;
         holdData_r   <= DATA_RESET;
         pendSpace_r  <= 1'b0;
         pendAddr_r   <= '0;
         pendData_r   <= DATA_RESET;
         pendLanesN_r <= LANES_OFF_N;
      end else begin
         state_r      <= state_nxt;
         cnt_r        <= cnt_nxt;
         accWrite_r   <= accWrite_nxt;
         accFlush_r   <= accFlush_nxt;
         accSpace_r   <= accSpace_nxt;
         accWide_r    <= accWide_nxt;
         accHalf_r    <= accHalf_nxt;
         accAddr_r    <= accAddr_nxt;
         accData_r    <= accData_nxt;
         accLanesN_r  <= accLanesN_nxt;
         holdSpace_r  <= holdSpace_nxt;
         holdAddr_r   <= holdAddr_nxt;
         holdData_r   <= holdData_nxt;
         pendSpace_r  <= pendSpace_nxt;
         pendAddr_r   <= pendAddr_nxt;
         pendData_r   <= pendData_nxt;
         pendLanesN_r <= pendLanesN_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         holdValid_r <= 1'b0;
         pend_r      <= 1'b0;
         cpuAck      <= 1'b0;
         cpuRdata    <= CPU_DATA_RESET;
      end else begin
         holdValid_r <= holdValid_nxt;
         pend_r      <= pend_nxt;
         cpuAck      <= ack_nxt;
         cpuRdata    <= rdata_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         portAddrLow          <= '0;
         portAddrHigh         <= '0;
         portDataOut          <= DATA_RESET;
         portDataOe           <= 1'b0;
         portByteLaneN        <= LANES_OFF_N;
         portSelectPrimaryN   <= 1'b1;
         portSelectSecondaryN <= 1'b1;
         portOutEnableN       <= 1'b1;
         portReadStrobeN      <= 1'b1;
         portWriteStrobeN     <= 1'b1;
      end else begin
         portAddrLow          <= accAddr_nxt[ADDR_LOW_W-1:0];
         portAddrHigh         <= addrHi_nxt;
         portDataOut          <= accData_nxt;
         portDataOe           <= active && accWrite_nxt;
         portByteLaneN        <= lanesN_nxt;
         portSelectPrimaryN   <= !(active && !accSpace_nxt);
         portSelectSecondaryN <= !(active && accSpace_nxt);
         portOutEnableN       <= !(active && !accWrite_nxt);
         portReadStrobeN      <= !(strobing && !accWrite_nxt);
         portWriteStrobeN     <= !(strobing && accWrite_nxt);
      end
   end

   // Peripheral routing, one cycle of register delay each way
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         serialTxDataFirst    <= 1'b1;
         serialTxDataSecond   <= 1'b1;
         serialTxDataSecondOe <= 1'b0;
         codecTx              <= 1'b1;
         cpuSerialRx          <= 2'h3;
         timerOutFirst        <= 1'b0;
         timerOutSecond       <= 1'b0;
         cardControlFirst     <= 1'b0;
         cardControlSecond    <= 1'b0;
      end else begin
         serialTxDataFirst    <= cpuSerialTx[0];
         serialTxDataSecond   <= cpuSerialTx[1];
         serialTxDataSecondOe <= shareCard;
         codecTx              <= shareCard ? 1'b1 : cpuSerialTx[1];
         cpuSerialRx          <= {shareCard ? syncOut[SYN_SRX + 1] : syncOut[SYN_CODEC],
                                  syncOut[SYN_SRX]};
         timerOutFirst        <= cpuTimerOut[0];
         timerOutSecond       <= cpuTimerOut[1];
         cardControlFirst     <= cpuCtrl[0];
         cardControlSecond    <= cpuCtrl[1];
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cardResetN <= 1'b0;
      end else begin
         cardResetN <= !cpuCardReset;
      end
   end

   // Card clock from a plain divider, no glitch since it is a flop
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         div_r        <= '0;
         cardClockOut <= 1'b0;
      end else if (div_r == DIV_W'(CLKOUT_HALF_CYC - 1)) begin
         div_r        <= '0;
         cardClockOut <= !cardClockOut;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

endmodule : epwa_adapter

`default_nettype wire

// ==== test/epwa_adapter_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module epwa_adapter_monitor (
   input wire logic       sys_clk, rstn, cpuAck, cpuCardReset, jumperShareCard, portDataOe,
   input wire logic       portSelectPrimaryN, portSelectSecondaryN, portOutEnableN, portReadyIn,
   input wire logic       portReadStrobeN, portWriteStrobeN, cardResetN, serialTxDataSecondOe,
   input wire logic       codecTx, cardClockOut,
   input wire logic [3:0] portByteLaneN
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // Six samples cover the ready filter lag
   sequence s_stall; (!portReadStrobeN && !portReadyIn) [*6]; endsequence
   sequence s_board; !jumperShareCard [*6]; endsequence
   a_sel_excl: assert property (portSelectPrimaryN || portSelectSecondaryN)
      else $error("both card selects low");
   a_strobe_excl: assert property (portReadStrobeN || portWriteStrobeN)
      else $error("read and write strobes low together");
   a_lanes_idle: assert property (portSelectPrimaryN && portSelectSecondaryN |-> portByteLaneN == 4'hF)
      else $error("byte lanes active without a select");
   a_strobe_min: assert property ($fell(portReadStrobeN) |-> !portReadStrobeN [*8])
      else $error("read strobe shorter than eight cycles");
   a_ready_stretch: assert property (s_stall |=> !portReadStrobeN)
      else $error("strobe ended while ready low");
   a_drive_dir: assert property (portDataOe |-> portOutEnableN && portReadStrobeN)
      else $error("data driven during a read");
   a_board_float: assert property (s_board |-> !serialTxDataSecondOe)
      else $error("card copy driven while board owns it");
   a_codec_idle: assert property (serialTxDataSecondOe |-> codecTx)
      else $error("codec driven while card owns the port");
   a_card_reset: assert property (cpuCardReset |=> !cardResetN)
      else $error("card reset not raised by software");
   a_ack_pulse: assert property ($rose(cpuAck) |=> !cpuAck)
      else $error("ack longer than one cycle");
   a_clock_div: assert property ($past(rstn) |-> $changed(cardClockOut))
      else $error("card clock did not toggle");
endmodule : epwa_adapter_monitor
bind epwa_adapter epwa_adapter_monitor u_epwa_adapter_monitor (.*);
`default_nettype wire

// ==== test/epwa_card_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module epwa_card_model (
   input wire logic        sys_clk, slow, portSelectPrimaryN, portSelectSecondaryN, portOutEnableN,
   input wire logic        portReadStrobeN, portWriteStrobeN,
   input wire logic [3:0]  portAddrLow, portByteLaneN, irqReq,
   input wire logic [31:0] portDataOut,
   output logic [31:0]     portDataIn,
   output logic            portReadyIn, cardIrqFirst, cardIrqSecond, cardIrqThird, cardIrqFourth
);
   logic [31:0] mem [16];
   logic [31:0] lastD = '0;
   int          wc = 0;
   wire logic   strobing = !(portReadStrobeN && portWriteStrobeN);
   assign {cardIrqFourth, cardIrqThird, cardIrqSecond, cardIrqFirst} = irqReq;
   // Four address bits; released bus keeps moving so stale data never passes
   // Secondary space answers inverted so the select in use shows in the data
   assign portDataIn = portOutEnableN ? ~lastD : mem[portAddrLow] ^ {32{!portSelectSecondaryN}};
   assign portReadyIn = !(slow && strobing && wc < 6);
   always @(posedge sys_clk) begin
      lastD <= portDataIn;
      wc <= strobing ? wc + 1 : 0;
      if (!portWriteStrobeN && !portSelectPrimaryN)
         for (int b = 0; b < 4; b++)
            if (!portByteLaneN[b]) mem[portAddrLow][8*b+:8] <= portDataOut[8*b+:8];
   end
endmodule : epwa_card_model
`default_nettype wire

// ==== test/epwa_adapter_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module epwa_adapter_test;
   typedef struct {logic w; logic [19:0] a; logic [15:0] d; logic [1:0] ln; logic fast;} epwa_row_s;
   logic sys_clk = 0, rstn = 0, cpuReq = 0, cpuWrite = 0, cpuSpace = 0, cpuCardReset = 0;
   logic slow = 0, jumperShareCard = 0, jumperWide = 1, cpuAck, portDataOe, codecTx;
   logic [19:0] cpuAddr = '0;
   logic [15:0] cpuWdata = '0, cpuRdata, portAddrHigh;
   logic [1:0]  cpuLaneN = '0, cpuStatus, cpuTimerIn, cpuSerialRx;
   logic [3:0]  irqReq = '0, cpuIrq, portAddrLow, portByteLaneN;
   logic [7:0]  pins = '0;
   logic [31:0] portDataOut, portDataIn;
   logic portSelectPrimaryN, portSelectSecondaryN, portOutEnableN, portReadStrobeN;
   logic portWriteStrobeN, portReadyIn, cardIrqFirst, cardIrqSecond, cardIrqThird;
   logic cardIrqFourth, cardResetN, cardControlFirst, cardControlSecond, cardClockOut;
   logic timerOutFirst, timerOutSecond, serialTxDataFirst, serialTxDataSecond, serialTxDataSecondOe;
   wire logic [1:0] cpuCtrl = pins[1:0], cpuTimerOut = pins[3:2], cpuSerialTx = pins[5:4];
   wire logic cardStatusFirst = pins[6], cardStatusSecond = pins[7], timerInFirst = pins[0];
   wire logic timerInSecond = pins[1], serialRxDataFirst = pins[2], serialRxDataSecond = pins[3];
   wire logic codecRx = pins[4];
   int n_fail = 0, compares = 0, cyc = 0, lat;
   epwa_row_s rows [11] = '{'{1, 20'h22, 16'h1234, 2'h0, 1}, '{1, 20'h23, 16'hABCD, 2'h0, 0},
      '{1, 20'h0, 16'h5678, 2'h0, 1}, '{1, 20'h1, 16'h9ABC, 2'h0, 0},
      '{0, 20'h22, 16'h1234, 2'h0, 0}, '{0, 20'h23, 16'hABCD, 2'h0, 1},
      '{0, 20'h0, 16'h5678, 2'h0, 0}, '{0, 20'h1, 16'h9ABC, 2'h0, 1},
      '{1, 20'h22, 16'h00EE, 2'h2, 1}, '{0, 20'h23, 16'hABCD, 2'h0, 0},
      '{0, 20'h22, 16'h12EE, 2'h0, 1}};
   epwa_adapter u_epwa_adapter (.*);
   epwa_card_model u_epwa_card_model (.*);
   initial forever #2.5 sys_clk = ~sys_clk;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic summarize();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   task automatic access(input epwa_row_s r);
      @(posedge sys_clk);
      {cpuReq, cpuWrite, cpuAddr, cpuWdata, cpuLaneN} <= {1'b1, r.w, r.a, r.d, r.ln};
      lat = 0;
      do begin @(negedge sys_clk); lat++; end while (cpuAck !== 1'b1 && lat < 200);
      check("ack", cpuAck, 1);
      @(posedge sys_clk) cpuReq <= 0;
   endtask : access
   // Hang guard well above the whole sequence
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin n_fail++; summarize(); end
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      rstn <= 1;
      repeat (8) @(posedge sys_clk);
      foreach (rows[i]) begin
         slow <= (i % 3 == 1);
         access(rows[i]);
         check("fastAck", 32'(lat <= 4), 32'(rows[i].fast));
         if (!rows[i].w) check("rdata", cpuRdata, rows[i].d);
      end
      check("addrHigh", portAddrHigh, 16'h1);
      jumperWide <= 0;
      repeat (8) @(posedge sys_clk);
      access('{1, 20'h5, 16'h4321, 2'h0, 0});
      check("fastAck", 32'(lat <= 4), 0);
      access('{0, 20'h5, 16'h4321, 2'h0, 0});
      check("rdata", cpuRdata, 16'h4321);
      cpuSpace <= 1;
      access('{0, 20'h5, 16'h4321, 2'h0, 0});
      check("rdata", cpuRdata, 16'hBCDE);
      pins <= 8'h96;
      repeat (8) @(posedge sys_clk);
      check("txOe", serialTxDataSecondOe, 0);
      check("codecTx", codecTx, 0);
      check("ctrl", {cardControlSecond, cardControlFirst}, 2'h2);
      check("tout", {timerOutSecond, timerOutFirst}, 2'h1);
      check("tx", {serialTxDataSecond, serialTxDataFirst}, 2'h1);
      check("inputs", {cpuStatus, cpuTimerIn}, 4'hA);
      check("rx", cpuSerialRx, 2'h3);
      jumperShareCard <= 1;
      cpuCardReset <= 1;
      repeat (8) @(posedge sys_clk);
      check("txOe", serialTxDataSecondOe, 1);
      check("codecTx", codecTx, 1);
      check("rx", cpuSerialRx, 2'h1);
      check("cardReset", cardResetN, 0);
      cpuCardReset <= 0;
      irqReq <= 4'h3;
      repeat (8) @(posedge sys_clk);
      check("irq", cpuIrq, 4'h3);
      check("cardReset", cardResetN, 1);
      rstn <= 0;
      repeat (2) @(posedge sys_clk);
      check("lanes", portByteLaneN, 4'hF);
      check("cardReset", cardResetN, 0);
      rstn <= 1;
      repeat (8) @(posedge sys_clk);
      check("txOe", serialTxDataSecondOe, 1);
      check("cardReset", cardResetN, 1);
      summarize();
   end
endmodule : epwa_adapter_test
`default_nettype wire
